// ==== hbridge_map.svh ====
// Offsets, fields, reset values and timing delays in ns of the H-bridge drive core.
`ifndef HBRIDGE_MAP_SVH
`define HBRIDGE_MAP_SVH
`define CFG_OFS 4'h0
`define STATCON_OFS 4'h4
`define DIAG1_OFS 4'h8
`define DIAG2_OFS 4'hc
`define CFG_MUX_BIT 0
`define CFG_RESET_BIT 1
`define CFG_FW_BIT 2
`define CFG_SPI_ROTATION_SENSE_BIT_BIT 3
`define CFG_SPI_PULSE_BIT_BIT 4
`define CFG_CL_LSB 5
`define CFG_RST_VAL 8'h62
`define SC_CLR1_BIT 0
`define SC_CLR2_BIT 1
`define SC_XFER_BIT 2
`define D_SCB 0
`define D_SCG 1
`define D_SCL 2
`define D_CLIM 3
`define D_THERM 4
`define BLANK_NS 10000
`define RETEST_NS 20000
`define DFDEL_NS 2000
`define DEADT_NS 500
`define CLK_NS 10
`endif

// ==== hbridge_pkg.sv ====
// Types shared by the H-bridge drive core.
package hbridge_pkg;
    typedef enum logic [3:0] {
        ST_LS_ON = 4'h0,
        ST_LS_OFF = 4'h1,
        ST_HS_ON = 4'h3,
        ST_HS_OFF = 4'h2,
        ST_REC = 4'h6,
        ST_DLS_OFF = 4'h7,
        ST_FAULT_OFF = 4'h5,
        ST_RETEST = 4'h4,
        ST_DISABLED = 4'hc
    } bridge_state_t;
    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } gate_cmd_t;
    typedef struct packed {
        logic hs_fast;
        logic ls_fast;
    } slew_t;
endpackage : hbridge_pkg

// ==== hbridge_drive_and_fault_control.sv ====
// H-bridge drive, current limit and short-circuit fault control core.
// Operation
// R1: control-source bit picks pins or register copies
// R2: disable by fault line or shutoff clears select
// R3: active freewheel on unless disable bit set
// R4: rotation sense 0 switches A, 1 switches B
// R5: pulse low turns low side, high turns high
// R6: low phase: high side off slowly, then low
// R7: high phase: low side off fast, then high
// R8: direction change: turn-off, then both lows on
// R9: phase two: new low off slowly, then high
// R10: shorts rechecked; confirmed fault latches, overload disables
// R11: host restarts by toggling shutoff or fault line
// R12: reset command clears addressed diagnosis register
// R13: config bit1 low resets registers, no restart
// R14: transfer-clear or toggle moves latched to history
// R15: sense the unswitched low side
// R16: sense moves only during double-low recirculation; the code also returns it to low side B on disable
// R17: limit: off after blanking, on below hysteresis
// R18: three selectable limit levels with overcurrent
// R19: current limitation logged in history register
// R20: thermal reduction lowers limit, shutdown switches off
// R21: early overcurrent flags short, staggered switch-off
// R22: second turn-on confirms, third decides overload
// R23: timing delays are parameterised cycle counters
`timescale 1ns/1ns
`include "hbridge_map.svh"
module hbridge_drive_and_fault_control #(
    parameter int BLANK_CYC = (`BLANK_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int RETEST_CYC = (`RETEST_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int DFDEL_CYC = (`DFDEL_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int DEAD_CYC = (`DEADT_NS + `CLK_NS - 1) / `CLK_NS
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Control pins.
    input wire logic dir_pin_i,
    input wire logic pwm_pin_i,
    input wire logic shutoff_i,
    input wire logic shared_fault_line_i,
    output logic shared_fault_line_o,
    output logic shared_fault_line_oe_n_o,
    // Analog comparators.
    input wire logic over_limit_i,
    input wire logic below_hyst_i,
    input wire logic overcurrent_i,
    input wire logic thermal_reduction_i,
    input wire logic thermal_shutdown_i,
    // Gate drive and sense.
    output hbridge_pkg::gate_cmd_t gate_o,
    output hbridge_pkg::slew_t slew_o,
    output logic [1:0] limit_level_o,
    output logic sense_ls_b_o,
    output logic enable_o
);
    initial begin
        if (BLANK_CYC < 1 || RETEST_CYC < 1 || DFDEL_CYC < 1 || DEAD_CYC < 1 ||
            BLANK_CYC > 65535 || RETEST_CYC > 65535 || DFDEL_CYC > 65535 ||
            DEAD_CYC > 65535) begin
            $error("timing counts must lie in 1..65535");
        end
    end

    // ********************************
    // Input synchronisers.
    // ********************************
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic [4:0] comp_meta_ff;
    logic [4:0] comp_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 5'h06;
            sync_ff <= 5'h06;
            comp_meta_ff <= 5'h00;
            comp_ff <= 5'h00;
        end else begin
            meta_ff <= {pwm_pin_i, dir_pin_i, shared_fault_line_i, 1'b1, shutoff_i};
            sync_ff <= meta_ff;
            comp_meta_ff <= {over_limit_i, below_hyst_i, overcurrent_i, thermal_reduction_i,
                thermal_shutdown_i};
            comp_ff <= comp_meta_ff;
        end
    end
    logic s_shutoff, s_line, s_dir_pin, s_pwm_pin;
    assign s_shutoff = sync_ff[0];
    assign s_line = sync_ff[2];
    assign s_dir_pin = sync_ff[3];
    assign s_pwm_pin = sync_ff[4];
    logic c_lim, c_hyst, c_oc, c_tred, c_tsd;
    assign {c_lim, c_hyst, c_oc, c_tred, c_tsd} = comp_ff;

    // ********************************
    // Register file.
    // ********************************
    logic [7:0] cfg_ff;
    logic [7:0] diag1_ff;
    logic [7:0] diag2_ff;
    logic fault_dis_ff;
    logic ext_off, off_d_ff, line_d_ff, restart;
    logic wr, wr_cfg, wr_sc, xfer, cfg_rst_wr;
    logic set_scb, set_scg, set_scl, log_clim;
    logic [7:0] cfg_wdata;
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign wr_cfg = wr && adr_i == `CFG_OFS;
    assign wr_sc = wr && adr_i == `STATCON_OFS;
    assign cfg_wdata = dat_i[7:0];
    assign ext_off = s_shutoff || !s_line;
    // Re-enable follows an off-then-on sequence of the shutoff input or fault line.
    assign restart = (off_d_ff && !s_shutoff) || (!line_d_ff && s_line); // R11
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            off_d_ff <= 1'b0;
            line_d_ff <= 1'b1;
        end else begin
            off_d_ff <= s_shutoff;
            line_d_ff <= s_line;
        end
    end

    // Configuration: a low reset bit restores defaults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= `CFG_RST_VAL;
        end else if (wr_cfg && !cfg_wdata[`CFG_RESET_BIT]) begin
            cfg_ff <= `CFG_RST_VAL; // R13
        end else if (ext_off) begin
            cfg_ff[`CFG_MUX_BIT] <= 1'b0; // R2
        end else if (wr_cfg) begin
            cfg_ff <= cfg_wdata;
        end
    end

    assign xfer = (wr_sc && dat_i[`SC_XFER_BIT]) || restart;
    assign cfg_rst_wr = wr_cfg && !cfg_wdata[`CFG_RESET_BIT];
    // Latched faults: hardware set wins over any clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diag1_ff <= 8'h00;
        end else begin
            if (cfg_rst_wr || xfer || (wr_sc && dat_i[`SC_CLR1_BIT])) begin
                diag1_ff <= 8'h00; // R12 R14
            end
            if (set_scb) begin
                diag1_ff[`D_SCB] <= 1'b1; // R10
            end
            if (set_scg) begin
                diag1_ff[`D_SCG] <= 1'b1; // R10
            end
            if (set_scl) begin
                diag1_ff[`D_SCL] <= 1'b1; // R22
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diag2_ff <= 8'h00;
        end else begin
            if (cfg_rst_wr || (wr_sc && dat_i[`SC_CLR2_BIT])) begin
                diag2_ff <= 8'h00; // R12 R13
            end
            if (xfer) begin
                diag2_ff <= diag2_ff | diag1_ff; // R14
            end
            if (log_clim) begin
                diag2_ff[`D_CLIM] <= 1'b1; // R19
            end
            if (c_tred || c_tsd) begin
                diag2_ff[`D_THERM] <= 1'b1; // R20
            end
        end
    end

    // Wishbone answer one cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            case (adr_i)
                `CFG_OFS: dat_o <= {24'h00_0000, cfg_ff};
                `STATCON_OFS: dat_o <= {30'h0000_0000, enable_o, fault_dis_ff};
                `DIAG1_OFS: dat_o <= {24'h00_0000, diag1_ff};
                `DIAG2_OFS: dat_o <= {24'h00_0000, diag2_ff};
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // Control source and sense.
    // ********************************
    logic dir_act, pwm_act;
    // Pins or register copies steer the bridge.
    assign dir_act = cfg_ff[`CFG_MUX_BIT] ? cfg_ff[`CFG_SPI_ROTATION_SENSE_BIT_BIT] : s_dir_pin; // R1
    assign pwm_act = cfg_ff[`CFG_MUX_BIT] ? cfg_ff[`CFG_SPI_PULSE_BIT_BIT] : s_pwm_pin; // R1
    assign limit_level_o = c_tred ? 2'h0 : cfg_ff[`CFG_CL_LSB +: 2]; // R18 R20

    // ********************************
    // Switching sequencer.
    // ********************************
    hbridge_pkg::bridge_state_t state_ff;
    logic dir_cur_ff;
    logic [15:0] cnt_ff;
    logic [1:0] tries_ff;
    logic short_hs_ff;
    logic limited_ff;
    logic cnt_done, on_phase, in_blank;
    logic [15:0] on_time_ff;
    assign cnt_done = cnt_ff == 16'h0000;
    assign on_phase = state_ff == hbridge_pkg::ST_HS_ON;
    always_ff @(posedge clk_i) begin
        if (rst_i || !on_phase) begin
            on_time_ff <= 16'h0000;
        end else if (on_time_ff != 16'hffff) begin
            on_time_ff <= on_time_ff + 16'h0001;
        end
    end
    assign in_blank = on_time_ff < 16'(BLANK_CYC); // R23
    assign set_scb = on_phase && enable_o && c_oc && in_blank && tries_ff == 2'h1 && !short_hs_ff;
    assign set_scg = on_phase && enable_o && c_oc && in_blank && tries_ff == 2'h1 && short_hs_ff;
    assign set_scl = on_phase && enable_o && c_oc && in_blank && tries_ff == 2'h2;
    assign log_clim = limited_ff || c_tred || c_tsd; // R19 R20

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_dis_ff <= 1'b0;
        end else if (set_scl) begin
            fault_dis_ff <= 1'b1; // R22
        end else if (restart) begin
            fault_dis_ff <= 1'b0; // R11
        end
    end
    assign enable_o = !fault_dis_ff && !ext_off && !c_tsd; // R20
    assign shared_fault_line_o = 1'b0;
    assign shared_fault_line_oe_n_o = !fault_dis_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limited_ff <= 1'b0;
        end else if (!on_phase || (limited_ff && c_hyst)) begin
            limited_ff <= 1'b0; // R17
        end else if (c_lim && !in_blank) begin
            limited_ff <= 1'b1; // R17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_o) begin
            state_ff <= hbridge_pkg::ST_LS_ON;
            dir_cur_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            tries_ff <= 2'h0;
            short_hs_ff <= 1'b0;
        end else begin
            if (!cnt_done) begin
                cnt_ff <= cnt_ff - 16'h0001;
            end
            case (state_ff)
                hbridge_pkg::ST_LS_ON: begin
                    if (dir_act != dir_cur_ff) begin
                        state_ff <= hbridge_pkg::ST_REC; // R8
                        cnt_ff <= 16'(DEAD_CYC);
                    end else if (pwm_act) begin
                        state_ff <= hbridge_pkg::ST_LS_OFF; // R7
                        cnt_ff <= 16'(DEAD_CYC);
                    end
                end
                hbridge_pkg::ST_LS_OFF: if (cnt_done) begin
                    state_ff <= hbridge_pkg::ST_HS_ON; // R7
                end
                hbridge_pkg::ST_HS_ON: begin
                    if (c_oc && in_blank) begin
                        state_ff <= hbridge_pkg::ST_FAULT_OFF; // R21
                        short_hs_ff <= 1'b1;
                        cnt_ff <= 16'(DFDEL_CYC);
                    end else if (!pwm_act || dir_act != dir_cur_ff) begin
                        state_ff <= hbridge_pkg::ST_HS_OFF; // R6 R8
                        cnt_ff <= 16'(DEAD_CYC);
                    end
                    if (!in_blank) begin
                        tries_ff <= 2'h0; // R22
                    end
                end
                hbridge_pkg::ST_HS_OFF: if (cnt_done) begin
                    state_ff <= hbridge_pkg::ST_LS_ON; // R6
                end
                hbridge_pkg::ST_REC: if (cnt_done) begin
                    state_ff <= hbridge_pkg::ST_DLS_OFF; // R9
                    dir_cur_ff <= dir_act;
                    cnt_ff <= 16'(DEAD_CYC);
                end
                hbridge_pkg::ST_DLS_OFF: if (cnt_done) begin
                    state_ff <= pwm_act ? hbridge_pkg::ST_HS_ON : hbridge_pkg::ST_LS_ON; // R9
                end
                hbridge_pkg::ST_FAULT_OFF: if (cnt_done) begin
                    state_ff <= hbridge_pkg::ST_RETEST; // R10
                    cnt_ff <= 16'(RETEST_CYC);
                end
                hbridge_pkg::ST_RETEST: if (cnt_done) begin
                    state_ff <= hbridge_pkg::ST_HS_ON; // R22
                    if (tries_ff != 2'h2) begin
                        tries_ff <= tries_ff + 2'h1; // R22
                    end
                end
                default: state_ff <= hbridge_pkg::ST_LS_ON;
            endcase
        end
    end

    // ********************************
    // Gate mapping.
    // ********************************
    logic hs_on, ls_on, other_ls, fw_on;
    always_comb begin
        fw_on = !cfg_ff[`CFG_FW_BIT]; // R3
        hs_on = 1'b0;
        ls_on = 1'b0;
        other_ls = 1'b1;
        case (state_ff)
            hbridge_pkg::ST_HS_ON: hs_on = !limited_ff; // R5 R17
            hbridge_pkg::ST_LS_ON: ls_on = fw_on; // R5
            hbridge_pkg::ST_REC: ls_on = 1'b1; // R8
            hbridge_pkg::ST_DLS_OFF: ls_on = 1'b0; // R9
            hbridge_pkg::ST_RETEST: other_ls = 1'b0; // R21
            default: other_ls = 1'b1;
        endcase
        if (!enable_o) begin
            hs_on = 1'b0;
            ls_on = 1'b0;
            other_ls = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_o <= '0;
            slew_o <= '0;
            sense_ls_b_o <= 1'b1;
        end else begin
            // Rotation sense picks which half-bridge carries the pulse.
            if (!dir_cur_ff) begin
                gate_o <= '{hs_a: hs_on, ls_a: ls_on, hs_b: 1'b0, ls_b: other_ls}; // R4
            end else begin
                gate_o <= '{hs_a: 1'b0, ls_a: other_ls, hs_b: hs_on, ls_b: ls_on}; // R4
            end
            slew_o.ls_fast <= state_ff != hbridge_pkg::ST_DLS_OFF; // R6 R7 R9
            slew_o.hs_fast <= 1'b0; // R6 R7
            if (state_ff == hbridge_pkg::ST_REC) begin
                sense_ls_b_o <= !dir_act; // R15 R16
            end else if (state_ff == hbridge_pkg::ST_LS_ON || state_ff == hbridge_pkg::ST_HS_ON) begin
                sense_ls_b_o <= !dir_cur_ff; // R15
            end
        end
    end

    // ********************************
    // Assertions.
    // ********************************
    no_shoot_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        !(gate_o.hs_a && gate_o.ls_a) && !(gate_o.hs_b && gate_o.ls_b))
        else $error("shoot-through on a half-bridge");
    hs_after_gap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        $rose(on_phase) |-> $past(state_ff) == hbridge_pkg::ST_LS_OFF ||
        $past(state_ff) == hbridge_pkg::ST_DLS_OFF || $past(state_ff) == hbridge_pkg::ST_RETEST)
        else $error("high side turned on without gap");
    mux_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        ext_off && !wr_cfg |=> !cfg_ff[`CFG_MUX_BIT])
        else $error("select not cleared on disable");
    scl_disable_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        set_scl |=> fault_dis_ff && diag1_ff[`D_SCL] && !enable_o)
        else $error("overload did not disable");
    xfer_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        xfer && !set_scb && !set_scg && !set_scl |=> diag1_ff == 8'h00 &&
        (diag2_ff & $past(diag1_ff)) == $past(diag1_ff) || $past(cfg_rst_wr))
        else $error("transfer clear failed");
    cfg_default_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        cfg_rst_wr |=> cfg_ff == `CFG_RST_VAL && !$rose(enable_o))
        else $error("config reset wrong");
    src_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        !cfg_ff[`CFG_MUX_BIT] |-> dir_act == s_dir_pin && pwm_act == s_pwm_pin)
        else $error("pin source not used");
    limit_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        limited_ff && on_phase |=> !gate_o.hs_a && !gate_o.hs_b)
        else $error("limited driver still on");
    short_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        on_phase && c_oc && in_blank && enable_o |=> state_ff == hbridge_pkg::ST_FAULT_OFF)
        else $error("short not acted on");
endmodule : hbridge_drive_and_fault_control

// ==== host_pin_model.sv ====
// Host side model: control pins and the pulled-up shared fault line.
`timescale 1ns/1ns
module host_pin_model (
    // Clock.
    input wire logic clk_i,
    // Requests from the bench.
    input wire logic dir_req_i,
    input wire logic pwm_req_i,
    input wire logic off_req_i,
    input wire logic line_low_req_i,
    // Device side.
    input wire logic line_oe_n_i,
    output logic dir_o,
    output logic pwm_o,
    output logic shutoff_o,
    output logic line_o
);
    // ******************************
    // Pins
    // ******************************
    initial begin
        dir_o = 1'b0;
        pwm_o = 1'b0;
        shutoff_o = 1'b0;
    end
    // Pins change only right after a rising edge; restart pulses pass here.
    always @(posedge clk_i) begin
        dir_o <= dir_req_i;
        pwm_o <= pwm_req_i;
        shutoff_o <= off_req_i;
    end
    // The line has a pull-up: low when anyone pulls it.
    assign line_o = !(line_low_req_i || !line_oe_n_i);
endmodule : host_pin_model

// ==== hbridge_drive_and_fault_control_bench.sv ====
// Self-checking bench of the H-bridge drive and fault core.
`timescale 1ns/1ns
module hbridge_drive_and_fault_control_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic dir_r = 1'b0, pwm_r = 1'b0, off_r = 1'b0, low_r = 1'b0;
    logic lim = 1'b0, hyst = 1'b0, oc = 1'b0, tred = 1'b0, thermal_shutdown_threshold = 1'b0;
    logic dir_p, pwm_p, off_p, line_p, line_o, oe_n, ack, sense, en;
    logic [31:0] rdat, q;
    logic [1:0] lvl;
    hbridge_pkg::gate_cmd_t gate;
    hbridge_pkg::slew_t slew;
    int miscompares = 0, comparisons = 0, cycles = 0, overlaps = 0;
    // ******************************
    // Instances
    // ******************************
    hbridge_drive_and_fault_control #(.BLANK_CYC(4), .RETEST_CYC(8), .DFDEL_CYC(2),
        .DEAD_CYC(2)) u_hbridge_drive_and_fault_control (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .dir_pin_i(dir_p), .pwm_pin_i(pwm_p),
        .shutoff_i(off_p), .shared_fault_line_i(line_p), .shared_fault_line_o(line_o),
        .shared_fault_line_oe_n_o(oe_n), .over_limit_i(lim), .below_hyst_i(hyst),
        .overcurrent_i(oc), .thermal_reduction_i(tred), .thermal_shutdown_i(thermal_shutdown_threshold),
        .gate_o(gate), .slew_o(slew), .limit_level_o(lvl), .sense_ls_b_o(sense),
        .enable_o(en));
    host_pin_model u_host_pin_model (.clk_i(clk_i), .dir_req_i(dir_r), .pwm_req_i(pwm_r),
        .off_req_i(off_r), .line_low_req_i(low_r), .line_oe_n_i(oe_n), .dir_o(dir_p),
        .pwm_o(pwm_p), .shutoff_o(off_p), .line_o(line_p));
    // ******************************
    // Clock, timeout and monitors
    // ******************************
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (!rst_i && ((gate.hs_a && gate.ls_a) || (gate.hs_b && gate.ls_b))) begin
            overlaps <= overlaps + 1;
        end
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ******************************
    // Helpers
    // ******************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) chk(32'h1, 32'h0);
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h0);
        chk(q, {24'h0, e});
    endtask : rd
    task automatic wait_gate(input logic [3:0] e);
        int n;
        n = 0;
        while (gate !== e && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk({28'h0, gate}, {28'h0, e});
    endtask : wait_gate
    task automatic pins(input logic d, input logic p);
        @(posedge clk_i);
        dir_r <= d;
        pwm_r <= p;
    endtask : pins
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ******************************
    // Scenarios
    // ******************************
    task automatic t_reset();
        rd(4'h0, 8'h62);
        rd(4'h8, 8'h00);
        rd(4'hc, 8'h00);
        rd(4'h2, 8'h00);
        wb(1'b1, 4'h2, 8'hff);
        rd(4'h0, 8'h62);
        chk({31'h0, sense}, 32'h1);
    endtask : t_reset
    task automatic t_pwm();
        pins(1'b0, 1'b1);
        wait_gate(4'b1001);
        pins(1'b0, 1'b0);
        wait_gate(4'b0101);
        pins(1'b0, 1'b1);
        wait_gate(4'b1001);
        chk(overlaps, 32'h0);
    endtask : t_pwm
    task automatic t_mux();
        wb(1'b1, 4'h0, 8'h7b);
        wait_gate(4'b0110);
        chk({31'h0, sense}, 32'h0);
        chk(overlaps, 32'h0);
        @(posedge clk_i);
        off_r <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({31'h0, en}, 32'h0);
        off_r <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(4'h0, 8'h7a);
        wait_gate(4'b1001);
        chk({31'h0, sense}, 32'h1);
    endtask : t_mux
    task automatic t_freewheel();
        wb(1'b1, 4'h0, 8'h66);
        pins(1'b0, 1'b0);
        wait_gate(4'b0001);
        repeat (8) @(posedge clk_i);
        chk({28'h0, gate}, 32'h1);
        wb(1'b1, 4'h0, 8'h62);
        wait_gate(4'b0101);
        pins(1'b0, 1'b1);
        wait_gate(4'b1001);
    endtask : t_freewheel
    task automatic t_levels();
        for (int l = 1; l < 4; l++) begin
            wb(1'b1, 4'h0, 8'h02 | (l[7:0] << 5));
            @(posedge clk_i);
            chk({30'h0, lvl}, l);
        end
        @(posedge clk_i);
        tred <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk({30'h0, lvl}, 32'h0);
        tred <= 1'b0;
        thermal_shutdown_threshold <= 1'b1;
        wait_gate(4'b0000);
        thermal_shutdown_threshold <= 1'b0;
        wait_gate(4'b1001);
        rd(4'hc, 8'h18);
        wb(1'b1, 4'h4, 8'h02);
        rd(4'hc, 8'h00);
    endtask : t_levels
    task automatic t_limit();
        @(posedge clk_i);
        lim <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({31'h0, gate.hs_a}, 32'h1);
        wait_gate(4'b0001);
        lim <= 1'b0;
        hyst <= 1'b1;
        wait_gate(4'b1001);
        hyst <= 1'b0;
        rd(4'hc, 8'h08);
    endtask : t_limit
    task automatic t_short();
        int n;
        n = 0;
        pins(1'b0, 1'b0);
        wait_gate(4'b0101);
        lim <= 1'b1;
        oc <= 1'b1;
        pins(1'b0, 1'b1);
        while (en !== 1'b0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        chk({31'h0, en}, 32'h0);
        chk({31'h0, oe_n}, 32'h0);
        chk({28'h0, gate}, 32'h0);
        lim <= 1'b0;
        oc <= 1'b0;
        rd(4'h8, 8'h06);
        wb(1'b1, 4'h4, 8'h04);
        rd(4'h8, 8'h00);
        chk(q & 32'h7, 32'h0);
        wb(1'b0, 4'hc, 8'h0);
        chk(q & 32'h7, 32'h6);
        wb(1'b1, 4'h0, 8'h60);
        rd(4'h0, 8'h62);
        chk({31'h0, en}, 32'h0);
        @(posedge clk_i);
        off_r <= 1'b1;
        repeat (4) @(posedge clk_i);
        off_r <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({31'h0, en}, 32'h1);
        chk({31'h0, oe_n}, 32'h1);
        wait_gate(4'b1001);
    endtask : t_short
    // ******************************
    // Main sequence
    // ******************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_pwm();
        t_mux();
        t_freewheel();
        t_levels();
        t_limit();
        t_short();
        end_of_test();
    end
endmodule : hbridge_drive_and_fault_control_bench
